/* rtl/epe_pkg.sv */
// constants and types for the enclave page permission extend block
package epe_pkg;
  localparam int ADDR_W = 64;
  localparam logic [31:0] LEAF_PERMISSION_EXTEND = 32'h0000_0006;
  localparam logic [63:0] INFO_ALIGN_MASK = 64'h0000_0000_0000_003f;
  localparam logic [63:0] PAGE_ALIGN_MASK = 64'h0000_0000_0000_0fff;
  localparam int INFO_W = 512;
  // security_info_record layout: flags r=0 w=1 x=2, bits 63:3 reserved
  localparam int FLAG_R_POS = 0;
  localparam int FLAG_W_POS = 1;
  localparam int FLAG_X_POS = 2;
  localparam logic [511:0] INFO_RSVD_MASK = {448'h0, 64'hffff_ffff_ffff_fff8};
  localparam logic [7:0] REGULAR_PAGE_TYPE = 8'h01;
  localparam logic [16:0] CANON_HIGH_ONES = 17'h1_ffff;
  // fault classes
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_GP = 2'h1;
  localparam logic [1:0] FAULT_PF = 2'h2;
  typedef enum logic [2:0] {
    EPE_IDLE = 3'h0,
    EPE_INFO_CHK = 3'h1,
    EPE_TGT_CHK = 3'h3,
    EPE_LOCK = 3'h2,
    EPE_RECHK = 3'h6,
    EPE_WRITE = 3'h7,
    EPE_DONE = 3'h5
  } epe_state_t;
endpackage

/* rtl/epe_addr_check.sv */
`timescale 1ns/1ps
// per-operand address checks: alignment, enclave range, segment limit, canonical form
module epe_addr_check (
  // operand
  input wire logic [63:0] addr,
  input wire logic [63:0] align_mask,
  // enclave and mode context
  input wire logic [63:0] range_base,
  input wire logic [63:0] range_limit,
  input wire logic [63:0] seg_limit,
  input wire logic mode_64,
  // results
  output logic misaligned,
  output logic out_of_range,
  output logic bad_form
);
  always_comb begin
    misaligned = (addr & align_mask) != 64'h0;
    out_of_range = (addr < range_base) || (addr > range_limit);
    if (mode_64) begin
      // upper 17 bits must all match bit 47
      bad_form = !((addr[63:47] == 17'h0) || (addr[63:47] == epe_pkg::CANON_HIGH_ONES));
    end else begin
      // operand spans a whole aligned unit, so test its first byte only
      bad_form = addr > seg_limit;
    end
  end
endmodule

/* rtl/epe_entry_check.sv */
`timescale 1ns/1ps
// checks one page_map_entry for a regular, settled page owned by the active enclave
module epe_entry_check (
  // entry fields
  input wire logic valid,
  input wire logic pending,
  input wire logic modified,
  input wire logic blocked,
  input wire logic [7:0] page_type,
  input wire logic [63:0] owner_control_ref,
  input wire logic [63:0] mapped_linear_addr,
  // expected values
  input wire logic [63:0] active_enclave_control,
  input wire logic [63:0] expect_addr,
  input wire logic check_blocked,
  input wire logic check_addr,
  // result
  output logic bad
);
  always_comb begin
    bad = !valid || pending || modified || (check_blocked && blocked)
          || (page_type != epe_pkg::REGULAR_PAGE_TYPE)
          || (owner_control_ref != active_enclave_control)
          || (check_addr && (mapped_linear_addr != expect_addr));
  end
endmodule

/* rtl/epe_permission_extend.sv */
`timescale 1ns/1ps
// permission extend leaf of the user enclave operation
// Behaviour
// [R01] leaf 06h of user_enclave_op selects permission_extend_leaf
// [R02] outside an enclave: general_protection_fault, error code zero
// [R03] requested rwx bits are ORed into the target rights, never removed
// [R04] first: record address not 64-byte aligned gives general_protection_fault
// [R05] then: target address not 4 KiB aligned gives general_protection_fault
// [R06] then: either address outside enclave_linear_range gives general_protection_fault
// [R07] record, then target, not in protected_page_cache gives page_fault
// [R08] record entry must be valid, readable, settled, regular, owned, mapped; else page_fault
// [R09] record copied to info_scratch_copy; nonzero reserved bits give general_protection_fault
// [R10] target entry must be valid, settled, unblocked, regular, owned; else page_fault
// [R11] target taken exclusively; already held gives general_protection_fault
// [R12] after lock recheck target entry plus mapped address; else page_fault
// [R13] target unreadable and write requested gives general_protection_fault
// [R14] protected mode: address beyond segment limit gives general_protection_fault
// [R15] 64-bit mode: non-canonical address gives general_protection_fault
// [R16] memory operand locked by another thread gives general_protection_fault
// [R17] leaf only available when second-generation feature is supported
// [R18] report completion or exactly one fault with class and address; no write on fault
// [R19] arithmetic status flags of the core stay unchanged
module epe_permission_extend (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // request from the core
  input wire logic op_valid,
  input wire logic [31:0] op_leaf,
  input wire logic [63:0] info_addr,
  input wire logic [63:0] target_addr,
  output logic op_ready,
  // core context
  input wire logic in_enclave,
  input wire logic gen2_supported,
  input wire logic mode_64,
  input wire logic [63:0] seg_limit,
  input wire logic [63:0] range_base,
  input wire logic [63:0] range_limit,
  input wire logic [63:0] active_enclave_control,
  input wire logic operand_locked,
  // record memory read
  output logic info_rd_req,
  input wire logic info_rd_ack,
  input wire logic [511:0] info_rd_data,
  // record page entry
  input wire logic info_in_cache,
  input wire logic info_valid,
  input wire logic info_read_ok,
  input wire logic info_pending,
  input wire logic info_modified,
  input wire logic info_blocked,
  input wire logic [7:0] info_page_type,
  input wire logic [63:0] info_owner,
  input wire logic [63:0] info_mapped,
  // target page entry
  input wire logic tgt_in_cache,
  input wire logic tgt_valid,
  input wire logic tgt_pending,
  input wire logic tgt_modified,
  input wire logic tgt_blocked,
  input wire logic [7:0] tgt_page_type,
  input wire logic [63:0] tgt_owner,
  input wire logic [63:0] tgt_mapped,
  input wire logic [2:0] tgt_rwx,
  // target exclusivity
  output logic lock_req,
  input wire logic lock_grant,
  input wire logic lock_busy,
  output logic lock_release,
  // target entry update
  output logic entry_wr,
  output logic [63:0] entry_wr_addr,
  output logic [2:0] entry_wr_rwx,
  // result to the core
  output logic done,
  output logic [1:0] fault_class,
  output logic [63:0] fault_addr,
  output logic [15:0] fault_code,
  output logic flags_write
);
  epe_pkg::epe_state_t state_reg;
  logic [63:0] info_addr_reg;
  logic [63:0] tgt_addr_reg;
  logic [511:0] info_scratch_copy;
  logic [1:0] fault_next;
  logic [63:0] fault_addr_next;
  logic finish;
  logic locked_reg;
  logic info_mis, info_oor, info_form;
  logic tgt_mis, tgt_oor, tgt_form;
  logic info_entry_bad, tgt_entry_bad, tgt_entry_rebad;
  logic req_r, req_w, req_x;

  epe_addr_check u_info_chk (
    .addr(info_addr),
    .align_mask(epe_pkg::INFO_ALIGN_MASK),
    .range_base(range_base),
    .range_limit(range_limit),
    .seg_limit(seg_limit),
    .mode_64(mode_64),
    .misaligned(info_mis),
    .out_of_range(info_oor),
    .bad_form(info_form)
  );

  // the target must start on a page boundary
  epe_addr_check u_tgt_chk (
    .addr(target_addr),
    .align_mask(epe_pkg::PAGE_ALIGN_MASK),
    .range_base(range_base),
    .range_limit(range_limit),
    .seg_limit(seg_limit),
    .mode_64(mode_64),
    .misaligned(tgt_mis),
    .out_of_range(tgt_oor),
    .bad_form(tgt_form)
  );

  // record entry, mapped at the record address with low 12 bits cleared
  epe_entry_check u_info_entry (
    .valid(info_valid),
    .pending(info_pending),
    .modified(info_modified),
    .blocked(info_blocked),
    .page_type(info_page_type),
    .owner_control_ref(info_owner),
    .mapped_linear_addr(info_mapped),
    .active_enclave_control(active_enclave_control),
    .expect_addr(info_addr_reg & ~epe_pkg::PAGE_ALIGN_MASK),
    .check_blocked(1'b1),
    .check_addr(1'b1),
    .bad(info_entry_bad)
  );

  epe_entry_check u_tgt_entry (
    .valid(tgt_valid),
    .pending(tgt_pending),
    .modified(tgt_modified),
    .blocked(tgt_blocked),
    .page_type(tgt_page_type),
    .owner_control_ref(tgt_owner),
    .mapped_linear_addr(tgt_mapped),
    .active_enclave_control(active_enclave_control),
    .expect_addr(tgt_addr_reg),
    .check_blocked(1'b1),
    .check_addr(1'b0),
    .bad(tgt_entry_bad)
  );

  // the recheck drops the blocked test but adds the mapped address
  epe_entry_check u_tgt_recheck (
    .valid(tgt_valid),
    .pending(tgt_pending),
    .modified(tgt_modified),
    .blocked(tgt_blocked),
    .page_type(tgt_page_type),
    .owner_control_ref(tgt_owner),
    .mapped_linear_addr(tgt_mapped),
    .active_enclave_control(active_enclave_control),
    .expect_addr(tgt_addr_reg),
    .check_blocked(1'b0),
    .check_addr(1'b1),
    .bad(tgt_entry_rebad)
  );

  assign req_r = info_scratch_copy[epe_pkg::FLAG_R_POS];
  assign req_w = info_scratch_copy[epe_pkg::FLAG_W_POS];
  assign req_x = info_scratch_copy[epe_pkg::FLAG_X_POS];

  // one operation at a time; later requests wait until the answer has gone
  assign op_ready = (state_reg == epe_pkg::EPE_IDLE);
  // no record fetch while a page fault is already decided for this cycle
  assign info_rd_req = (state_reg == epe_pkg::EPE_INFO_CHK) && !info_entry_bad
                       && info_in_cache && tgt_in_cache && info_read_ok;
  assign lock_req = (state_reg == epe_pkg::EPE_LOCK) && !locked_reg;

  // sequencing and fault selection in documented order
  always_comb begin
    fault_next = epe_pkg::FAULT_NONE;
    fault_addr_next = 64'h0;
    finish = 1'b0;
    case (state_reg)
      epe_pkg::EPE_IDLE: begin
        // early refusals share class and code, so their order cannot be seen
        if (op_valid && op_leaf == epe_pkg::LEAF_PERMISSION_EXTEND) begin // [R01]
          finish = 1'b1;
          if (!gen2_supported) fault_next = epe_pkg::FAULT_GP; // [R17]
          else if (!in_enclave) fault_next = epe_pkg::FAULT_GP; // [R02]
          else if (info_form || tgt_form) fault_next = epe_pkg::FAULT_GP; // [R14] [R15]
          else if (operand_locked) fault_next = epe_pkg::FAULT_GP; // [R16]
          else if (info_mis) fault_next = epe_pkg::FAULT_GP; // [R04]
          else if (tgt_mis) fault_next = epe_pkg::FAULT_GP; // [R05]
          else if (info_oor || tgt_oor) fault_next = epe_pkg::FAULT_GP; // [R06]
          else finish = 1'b0;
        end
      end
      epe_pkg::EPE_INFO_CHK: begin
        fault_addr_next = info_addr_reg;
        if (!info_in_cache) begin // [R07]
          fault_next = epe_pkg::FAULT_PF;
          finish = 1'b1;
        end else if (!tgt_in_cache) begin // [R07]
          fault_next = epe_pkg::FAULT_PF;
          fault_addr_next = tgt_addr_reg;
          finish = 1'b1;
        end else if (info_entry_bad || !info_read_ok) begin // [R08]
          fault_next = epe_pkg::FAULT_PF;
          finish = 1'b1;
        end
      end
      epe_pkg::EPE_TGT_CHK: begin
        finish = 1'b1;
        if ((info_scratch_copy & epe_pkg::INFO_RSVD_MASK) != 512'h0) begin // [R09]
          fault_next = epe_pkg::FAULT_GP;
        end else if (tgt_entry_bad) begin // [R10]
          fault_next = epe_pkg::FAULT_PF;
          fault_addr_next = tgt_addr_reg;
        end else begin
          finish = 1'b0;
        end
      end
      epe_pkg::EPE_LOCK: begin
        // once held, a later busy report from elsewhere no longer matters
        if (lock_busy && !locked_reg) begin // [R11]
          fault_next = epe_pkg::FAULT_GP;
          finish = 1'b1;
        end
      end
      epe_pkg::EPE_RECHK: begin
        finish = 1'b1;
        if (tgt_entry_rebad) begin // [R12]
          fault_next = epe_pkg::FAULT_PF;
          fault_addr_next = tgt_addr_reg;
        end else if (!tgt_rwx[epe_pkg::FLAG_R_POS] && req_w) begin // [R13]
          fault_next = epe_pkg::FAULT_GP;
        end else begin
          finish = 1'b0;
        end
      end
      default: begin
        finish = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= epe_pkg::EPE_IDLE;
    end else if (finish) begin
      state_reg <= epe_pkg::EPE_DONE;
    end else begin
      case (state_reg)
        epe_pkg::EPE_IDLE: begin
          if (op_valid && op_leaf == epe_pkg::LEAF_PERMISSION_EXTEND) begin
            state_reg <= epe_pkg::EPE_INFO_CHK;
          end
        end
        epe_pkg::EPE_INFO_CHK: begin
          if (info_rd_ack) state_reg <= epe_pkg::EPE_TGT_CHK;
        end
        epe_pkg::EPE_TGT_CHK: state_reg <= epe_pkg::EPE_LOCK;
        epe_pkg::EPE_LOCK: begin
          if (locked_reg) state_reg <= epe_pkg::EPE_RECHK;
        end
        epe_pkg::EPE_RECHK: state_reg <= epe_pkg::EPE_WRITE;
        epe_pkg::EPE_WRITE: state_reg <= epe_pkg::EPE_DONE;
        epe_pkg::EPE_DONE: state_reg <= epe_pkg::EPE_IDLE;
        default: state_reg <= epe_pkg::EPE_IDLE;
      endcase
    end
  end

  // operands held for the whole operation
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      info_addr_reg <= 64'h0;
      tgt_addr_reg <= 64'h0;
    end else if (op_ready && op_valid) begin
      info_addr_reg <= info_addr;
      tgt_addr_reg <= target_addr;
    end
  end

  // record copy is the only view used later, so a racing store cannot change it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      info_scratch_copy <= 512'h0;
    end else if (info_rd_req && info_rd_ack) begin
      info_scratch_copy <= info_rd_data; // [R09]
    end
  end

  // exclusive hold on the target; released whenever the operation ends
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      locked_reg <= 1'b0;
    end else if (state_reg == epe_pkg::EPE_DONE) begin
      locked_reg <= 1'b0;
    end else if (lock_req && lock_grant && !lock_busy) begin
      locked_reg <= 1'b1; // [R11]
    end
  end

  assign lock_release = (state_reg == epe_pkg::EPE_DONE) && locked_reg;

  // entry write only on the fault-free path
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      entry_wr <= 1'b0;
      entry_wr_addr <= 64'h0;
      entry_wr_rwx <= 3'h0;
    end else begin
      // rights only grow: the old entry is ORed with the request, never replaced
      entry_wr <= (state_reg == epe_pkg::EPE_RECHK) && !finish; // [R18]
      if ((state_reg == epe_pkg::EPE_RECHK) && !finish) begin
        entry_wr_addr <= tgt_addr_reg;
        entry_wr_rwx <= tgt_rwx | {req_x, req_w, req_r}; // [R03]
      end
    end
  end

  // one result per operation; flags never written
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      done <= 1'b0;
      fault_class <= epe_pkg::FAULT_NONE;
      fault_addr <= 64'h0;
      fault_code <= 16'h0;
    end else begin
      done <= (finish && fault_next != epe_pkg::FAULT_NONE)
              || (state_reg == epe_pkg::EPE_WRITE); // [R18]
      if (finish || state_reg == epe_pkg::EPE_WRITE) begin
        fault_class <= fault_next; // [R18]
        fault_addr <= (fault_next == epe_pkg::FAULT_PF) ? fault_addr_next : 64'h0;
        fault_code <= 16'h0; // [R02]
      end
    end
  end

  assign flags_write = 1'b0; // [R19]
endmodule

/* tb/epe_checker.sv */
// port assertions for the permission extend block
`timescale 1ns/1ps
module epe_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // request and context
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic [31:0] op_leaf,
  input wire logic [63:0] info_addr,
  input wire logic [63:0] target_addr,
  input wire logic in_enclave,
  input wire logic gen2_supported,
  input wire logic operand_locked,
  input wire logic [2:0] tgt_rwx,
  input wire logic lock_req,
  input wire logic lock_busy,
  input wire logic lock_release,
  // results
  input wire logic entry_wr,
  input wire logic [2:0] entry_wr_rwx,
  input wire logic done,
  input wire logic [1:0] fault_class,
  input wire logic [63:0] fault_addr,
  input wire logic [15:0] fault_code,
  input wire logic flags_write
);
  logic take;
  logic ok;
  assign take = op_valid && op_ready && op_leaf == epe_pkg::LEAF_PERMISSION_EXTEND;
  assign ok = take && gen2_supported && in_enclave;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence gp_now;
    done && fault_class == epe_pkg::FAULT_GP;
  endsequence
  chk_no_feature: assert property (take && !gen2_supported |=> gp_now)
    else $error("missing feature not refused");
  chk_no_enclave: assert property (take && gen2_supported && !in_enclave |=> gp_now)
    else $error("outside enclave not refused");
  chk_code_zero: assert property (done |-> fault_code == 16'h0)
    else $error("fault code not zero");
  chk_operand_locked: assert property (ok && operand_locked |=> gp_now)
    else $error("locked operand not refused");
  chk_info_align: assert property (
    ok && |(info_addr & epe_pkg::INFO_ALIGN_MASK) |=> gp_now)
    else $error("record misalignment not refused");
  chk_tgt_align: assert property (
    ok && |(target_addr & epe_pkg::PAGE_ALIGN_MASK) |=> gp_now)
    else $error("target misalignment not refused");
  chk_rights_kept: assert property (entry_wr |-> (entry_wr_rwx & tgt_rwx) == tgt_rwx)
    else $error("rights removed");
  chk_write_done: assert property (
    entry_wr |=> done && fault_class == epe_pkg::FAULT_NONE)
    else $error("write without completion");
  chk_addr_clear: assert property (
    done && fault_class != epe_pkg::FAULT_PF |-> fault_addr == 64'h0)
    else $error("fault address without page fault");
  chk_lock_held: assert property (lock_req && lock_busy |-> ##[1:2] gp_now)
    else $error("held page not refused");
  chk_lock_free: assert property (entry_wr |=> lock_release)
    else $error("page hold not given back");
  chk_flags_same: assert property (!flags_write)
    else $error("status flags written");
  chk_ready_after: assert property (done |=> op_ready && !done)
    else $error("not idle after answer");
  cover property (entry_wr);
  cover property (done && fault_class == epe_pkg::FAULT_GP);
  cover property (done && fault_class == epe_pkg::FAULT_PF);
  cover property (lock_req && lock_busy);
endmodule
bind epe_permission_extend epe_checker u_chk (.*);

/* tb/epe_far_model.sv */
// far side model: record memory and page lock responder
`timescale 1ns/1ps
module epe_far_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // knobs from the bench
  input wire logic [1:0] resp_delay,
  input wire logic lock_busy,
  input wire logic [511:0] info_rec,
  // record read
  input wire logic info_rd_req,
  output logic info_rd_ack,
  output logic [511:0] info_rd_data,
  // page lock
  input wire logic lock_req,
  output logic lock_grant
);
  logic [1:0] rd_cnt_reg;
  logic [1:0] lk_cnt_reg;
  // answers wait a chosen number of cycles, so slow memory is exercised too
  assign info_rd_ack = info_rd_req && rd_cnt_reg == resp_delay;
  // outside an answer the data is inverted, never a stale copy
  assign info_rd_data = info_rd_ack ? info_rec : ~info_rec;
  // a page held elsewhere is never granted
  assign lock_grant = lock_req && !lock_busy && lk_cnt_reg == resp_delay;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !info_rd_req || info_rd_ack) rd_cnt_reg <= 2'h0;
    else rd_cnt_reg <= rd_cnt_reg + 2'h1;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst || !lock_req || lock_grant) lk_cnt_reg <= 2'h0;
    else lk_cnt_reg <= lk_cnt_reg + 2'h1;
  end
endmodule

/* tb/tb.sv */
// self-checking bench for the permission extend block
`timescale 1ns/1ps
module tb;
  typedef struct {logic [1:0] cls; logic [63:0] adr; logic wr; logic [2:0] rwx;} epe_exp_t;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  logic [31:0] op_leaf;
  logic [63:0] info_addr, target_addr, seg_limit, range_base, range_limit;
  logic [63:0] active_enclave_control, info_owner, info_mapped, tgt_owner, tgt_mapped;
  logic in_enclave, gen2_supported, mode_64, operand_locked, lock_busy;
  logic info_in_cache, info_valid, info_read_ok, info_pending, info_modified, info_blocked;
  logic tgt_in_cache, tgt_valid, tgt_pending, tgt_modified, tgt_blocked;
  logic [7:0] info_page_type, tgt_page_type;
  logic [2:0] tgt_rwx, rwx_req, entry_wr_rwx, saw_rwx;
  logic [1:0] resp_delay, fault_class;
  logic [511:0] info_rec, info_rd_data;
  logic op_ready, info_rd_req, info_rd_ack, lock_req, lock_grant, lock_release;
  logic entry_wr, done, flags_write;
  logic saw_wr = 1'b0;
  logic [63:0] saw_adr;
  logic [63:0] entry_wr_addr, fault_addr;
  logic [15:0] fault_code;
  epe_exp_t exp_q[$];
  int seed = 32'h0e0b;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  epe_permission_extend DUT (.*);
  epe_far_model u_far (.*);
  initial forever #50 core_clk = ~core_clk;
  task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // a clean request: every check passes, random rights and operands
  task automatic good();
    {in_enclave, gen2_supported, mode_64, operand_locked, lock_busy} = 5'b11100;
    {info_in_cache, info_valid, info_read_ok, info_pending, info_modified, info_blocked} = 6'h38;
    {tgt_in_cache, tgt_valid, tgt_pending, tgt_modified, tgt_blocked} = 5'h18;
    {info_page_type, tgt_page_type} = {2{epe_pkg::REGULAR_PAGE_TYPE}};
    {range_base, range_limit} = {64'h0000_0000_1000_0000, 64'h0000_0000_1fff_ffff};
    seg_limit = 64'hffff_ffff_ffff_ffff;
    active_enclave_control = 64'h0000_0000_0000_0a5a;
    {info_owner, tgt_owner} = {2{active_enclave_control}};
    info_addr = range_base + 64'($random(seed) & 32'h00ff_ffc0);
    target_addr = range_base + 64'($random(seed) & 32'h0fff_f000);
    info_mapped = info_addr & ~epe_pkg::PAGE_ALIGN_MASK;
    tgt_mapped = target_addr;
    rwx_req = 3'($random(seed));
    tgt_rwx = 3'($random(seed)) | 3'h1;
    info_rec = {509'h0, rwx_req};
    resp_delay = 2'($random(seed));
    op_leaf = epe_pkg::LEAF_PERMISSION_EXTEND;
  endtask
  task automatic run(input int k, input int r);
    epe_exp_t e;
    good();
    e = '{epe_pkg::FAULT_GP, 64'h0, 1'b0, 3'h0};
    case (k)
      0: e = '{epe_pkg::FAULT_NONE, 64'h0, 1'b1, tgt_rwx | rwx_req};
      1: gen2_supported = 1'b0;
      2: in_enclave = 1'b0;
      // full range, so only the form check can refuse this one
      3: {info_addr[62], range_limit} = {1'b1, 64'hffff_ffff_ffff_ffff};
      4: {mode_64, seg_limit} = {1'b0, target_addr - 64'h1};
      5: operand_locked = 1'b1;
      6: info_addr[3] = 1'b1;
      7: target_addr[5] = 1'b1;
      8: target_addr = range_limit + 64'h1;
      9: {info_in_cache, tgt_in_cache} = 2'b00;
      10: tgt_in_cache = 1'b0;
      11: begin
        case (r)
          0: info_valid = 1'b0;
          1: info_read_ok = 1'b0;
          2: info_pending = 1'b1;
          3: info_modified = 1'b1;
          4: info_blocked = 1'b1;
          5: info_page_type = 8'h02;
          6: info_owner = 64'h1;
          default: info_mapped = info_mapped ^ 64'h1000;
        endcase
        tgt_valid = 1'b0;
      end
      12: info_rec[3 + r * 7] = 1'b1;
      13: begin
        case (r % 6)
          0: tgt_valid = 1'b0;
          1: tgt_pending = 1'b1;
          2: tgt_modified = 1'b1;
          3: tgt_blocked = 1'b1;
          4: tgt_page_type = 8'h02;
          default: tgt_owner = 64'h1;
        endcase
      end
      14: lock_busy = 1'b1;
      15: tgt_mapped = target_addr + 64'h1000;
      16: {tgt_rwx, info_rec[1]} = 4'h9;
      default: op_leaf = 32'h0000_0007;
    endcase
    if (k == 9 || k == 11) e = '{epe_pkg::FAULT_PF, info_addr, 1'b0, 3'h0};
    if (k == 10 || k == 13 || k == 15) e = '{epe_pkg::FAULT_PF, target_addr, 1'b0, 3'h0};
    if (k < 17) exp_q.push_back(e);
    op_valid = 1'b1;
    @(negedge core_clk);
    op_valid = 1'b0;
    for (int i = 0; i < 30 && done !== 1'b1; i++) @(negedge core_clk);
    @(negedge core_clk);
  endtask
  // monitor: each answer takes the oldest note
  always @(negedge core_clk) begin
    epe_exp_t e;
    if (entry_wr === 1'b1) {saw_wr, saw_rwx, saw_adr} = {1'b1, entry_wr_rwx, entry_wr_addr};
    if (done === 1'b1) begin
      if (exp_q.size() == 0) check(64'h1, 64'h0, "unexpected answer");
      else begin
        e = exp_q.pop_front();
        check(64'(fault_class), 64'(e.cls), "fault class");
        check(fault_addr, e.adr, "fault address");
        check(64'(saw_wr), 64'(e.wr), "entry write");
        if (e.wr) check(64'(saw_rwx), 64'(e.rwx), "new rights");
        if (e.wr) check(saw_adr, target_addr, "entry address");
      end
      saw_wr = 1'b0;
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    good();
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int r = 0; r < 8; r++) for (int k = 0; k < 18; k++) run(k, r);
    repeat (5) @(negedge core_clk);
    check(64'(exp_q.size()), 64'h0, "answers missing");
    complete_run();
  end
endmodule
